//--- afe_pkg.sv
// Purpose : Shared constants and types for the front-end control block
// Assumes : 32-bit AXI4-Lite register access, one aligned word per register
// Notes   : Register indices are word indices; byte address = index * 4
`default_nettype none

package afe_pkg;

    // ----------------------------------------------------------------
    // Bus and code widths
    // ----------------------------------------------------------------
    localparam int          AFE_ADDR_W     = 8;
    localparam int          AFE_DATA_W     = 32;
    localparam int          AFE_CODE_W     = 24;
    localparam logic [1:0]  AFE_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  AFE_RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // Register indices
    // ----------------------------------------------------------------
    localparam logic [5:0]  IDX_ADC_CTRL   = 6'h01;
    localparam logic [5:0]  IDX_RESULT     = 6'h02;
    localparam logic [5:0]  IDX_IO_CTRL    = 6'h03;
    localparam logic [5:0]  IDX_STATUS     = 6'h05;
    localparam logic [5:0]  IDX_SETUP_CFG  = 6'h19;
    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_ADC_CTRL   = 32'h0000_0000;
    localparam logic [31:0] RST_IO_CTRL    = 32'h0000_0000;
    localparam logic [31:0] RST_SETUP_CFG  = 32'h0000_0860;
    localparam logic [31:0] MASK_ADC_CTRL  = 32'h0000_1fff;
    localparam logic [31:0] MASK_IO_CTRL   = 32'h00ff_bfff;
    localparam logic [31:0] MASK_SETUP_CFG = 32'h0000_0fff;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          CTRL_REF_ON_BIT = 0;
    localparam int          IO_VAL_LSB     = 20;
    localparam int          IO_OE_LSB      = 16;
    localparam int          IO_SW_BIT      = 15;
    localparam int          IO_MAG_B_LSB   = 11;
    localparam int          IO_MAG_A_LSB   = 8;
    localparam int          IO_PIN_B_LSB   = 4;
    localparam int          IO_PIN_A_LSB   = 0;
    localparam int          CFG_POLAR_BIT  = 11;
    localparam int          CFG_REFSEL_LSB = 3;
    localparam int          CFG_GAIN_LSB   = 0;
    localparam int          STAT_NEW_BIT   = 0;
    // Gain codes: 0 is x1, 1..3 are x2..x8, 4..7 are x16..x128
    localparam logic [2:0]  GAIN_BYPASS_MAX = 3'h0;
    localparam logic [2:0]  GAIN_ONE_MAX    = 3'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        AFE_REF_EXT_A    = 2'b00,
        AFE_REF_EXT_B    = 2'b01,
        AFE_REF_INTERNAL = 2'b10,
        AFE_REF_RESERVED = 2'b11
    } afe_ref_e;

    typedef struct packed {
        logic       stage_a_en;      // First amplifier stage in use
        logic       stage_b_en;      // Second amplifier stage in use
        logic [2:0] gain_select;     // Gain is 2**gain_select
        logic       int_ref_power;   // Embedded reference powered
        afe_ref_e   ref_route;       // Reference fed to modulator
        logic       bipolar;         // Offset binary range
        logic [2:0] current_a_magnitude;
        logic [2:0] current_b_magnitude;
        logic [3:0] current_a_pin_select;
        logic [3:0] current_b_pin_select;
        logic       bridge_switch_close;
    } afe_drive_s;

endpackage : afe_pkg

`default_nettype wire

//--- afe_code_format.sv
// Purpose : Turns a signed scaled sample into a straight or offset binary code
// Assumes : Sample = input * gain / reference * 2**W, signed, same clock
// Notes   : Out-of-range samples saturate to all zeros or all ones
`default_nettype none

module afe_code_format
    import afe_pkg::*;
#(
    parameter int W = AFE_CODE_W
) (
    input  wire logic               clk,          // System clock
    input  wire logic               resetn,       // Sync reset, active low
    input  wire logic               bipolar,      // 1: offset binary
    input  wire logic               sample_valid, // Sample strobe
    input  wire logic signed [W:0]  sample,       // Scaled signed sample
    output logic                    code_valid_ff, // Code strobe
    output logic        [W-1:0]     code_ff       // Formatted code
);

    localparam logic signed [W+1:0] TOP  = (W+2)'((1 << W) - 1);
    localparam logic signed [W+1:0] HALF = (W+2)'(1 << (W-1));

    logic signed [W+1:0] wide;
    logic signed [W+1:0] nxt_code;

    // ----------------------------------------------------------------
    // Scaling and saturation
    // ----------------------------------------------------------------
    always_comb begin
        wide = {sample[W], sample};
        if (bipolar) begin
            nxt_code = (wide >>> 1) + HALF;
        end else begin
            nxt_code = wide;
        end
        if (nxt_code < 0) begin
            nxt_code = '0;
        end else if (nxt_code > TOP) begin
            nxt_code = TOP;
        end
    end

    // Register the code so outputs come from flops
    always_ff @(posedge clk) begin
        if (!resetn) begin
            code_valid_ff <= 1'b0;
            code_ff       <= '0;
        end else begin
            code_valid_ff <= sample_valid;
            if (sample_valid) begin
                code_ff <= nxt_code[W-1:0];
            end
        end
    end

endmodule : afe_code_format

`default_nettype wire

//--- afe_control.sv
// Purpose : Front-end control register bank and result code formatting
// Assumes : AXI4-Lite slave, 40 MHz clk, synchronous active-low reset
// Notes   : Overview of operation below; analog parts sit outside
//
// Overview of operation
// - Gain is 1 to 128 in powers of two, from the setup gain field.
// - Gain 1 bypasses both stages, 2-8 uses one, above 8 uses both.
// - Control reference-enable bit set powers the embedded reference.
// - Setup reference select routes external A, external B or internal.
// - Setup polarity bit picks unipolar or bipolar input range.
// - Unipolar result is straight binary, zero to all ones.
// - Bipolar result is offset binary, midscale code at zero input.
// - Codes are 24 bits and follow the unipolar and bipolar formulas.
// - Two current sources with independent three-bit magnitude fields.
// - Each source has its own pin select; both may share one pin.
// - Switch control bit closes the bridge switch, clear opens it.
// - Each general output is driven only while its enable bit is set.
// - An enabled general output drives its value bit level.
// - Current sources work whether or not the reference is enabled.
// - I/O control register, 24 bits, reset zero, with fixed field layout.
`default_nettype none

module afe_control
    import afe_pkg::*;
(
    input  wire logic                  clk,              // 40 MHz clock
    input  wire logic                  resetn,           // Sync reset, active low
    // AXI4-Lite write address
    input  wire logic [AFE_ADDR_W-1:0] s_axi_awaddr,     // Write byte address
    input  wire logic                  s_axi_awvalid,    // Address valid
    output logic                       s_axi_awready,    // Address taken
    // AXI4-Lite write data
    input  wire logic [31:0]           s_axi_wdata,      // Write data
    input  wire logic [3:0]            s_axi_wstrb,      // Byte enables
    input  wire logic                  s_axi_wvalid,     // Data valid
    output logic                       s_axi_wready,     // Data taken
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,      // Write status
    output logic                       s_axi_bvalid,     // Response valid
    input  wire logic                  s_axi_bready,     // Response taken
    // AXI4-Lite read address
    input  wire logic [AFE_ADDR_W-1:0] s_axi_araddr,     // Read byte address
    input  wire logic                  s_axi_arvalid,    // Address valid
    output logic                       s_axi_arready,    // Address taken
    // AXI4-Lite read data
    output logic [31:0]                s_axi_rdata,      // Read data
    output logic [1:0]                 s_axi_rresp,      // Read status
    output logic                       s_axi_rvalid,     // Data valid
    input  wire logic                  s_axi_rready,     // Data taken
    // Conversion sample in, formatted result out
    input  wire logic                  sample_valid,     // Sample strobe
    input  wire logic [AFE_CODE_W:0]   sample_value,     // Signed scaled sample
    output logic                       result_valid,     // Code strobe
    output logic [AFE_CODE_W-1:0]      result_code,      // Formatted code
    // Analog front-end drive
    output afe_drive_s                 afe_drive,        // Gain, reference, currents
    output logic [3:0]                 general_output_pins,    // Output levels
    output logic [3:0]                 general_output_pins_oe, // Output enables
    output logic                       filter_reset      // Restart pulse
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic                  awready_ff;
    logic                  wready_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  arready_ff;
    logic                  rvalid_ff;
    logic [1:0]            rresp_ff;
    logic [31:0]           rdata_ff;
    logic                  aw_held_ff;
    logic                  w_held_ff;
    logic [AFE_ADDR_W-1:0] aw_addr_ff;
    logic [31:0]           w_data_ff;
    logic [3:0]            w_strb_ff;
    logic [31:0]           adc_ctrl_ff;
    logic [31:0]           io_ctrl_ff;
    logic [31:0]           setup_cfg_ff;
    logic                  result_new_ff;
    logic [AFE_CODE_W-1:0] result_hold;
    logic                  code_valid;
    afe_drive_s            drive_ff;
    afe_drive_s            nxt_drive;
    logic [3:0]            gpo_ff;
    logic [3:0]            gpo_oe_ff;
    logic                  filter_reset_ff;
    logic                  wr_fire;
    logic                  rd_fire;
    logic [5:0]            wr_idx;
    logic [5:0]            rd_idx;
    logic                  wr_hit;
    logic                  rd_hit;

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // Word index of a byte address; low two bits ignored
    function automatic logic [5:0] reg_index(input logic [AFE_ADDR_W-1:0] addr);
        reg_index = addr[7:2];
    endfunction : reg_index

    // Merge enabled byte lanes, then keep only writable bits
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb,
        input logic [31:0] mask
    );
        logic [31:0] merged;
        merged = old_val;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merged[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        merge_lanes = merged & mask;
    endfunction : merge_lanes

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign rd_fire = s_axi_arvalid && arready_ff;
    assign wr_idx  = reg_index(aw_addr_ff);
    assign rd_idx  = reg_index(s_axi_araddr);
    // Result and status are read-only, so writes to them are refused
    assign wr_hit  = (wr_idx == IDX_ADC_CTRL) || (wr_idx == IDX_IO_CTRL) ||
                     (wr_idx == IDX_SETUP_CFG);
    assign rd_hit  = wr_hit_rd(rd_idx);

    function automatic logic wr_hit_rd(input logic [5:0] idx);
        wr_hit_rd = (idx == IDX_ADC_CTRL) || (idx == IDX_IO_CTRL) ||
                    (idx == IDX_SETUP_CFG) || (idx == IDX_RESULT) ||
                    (idx == IDX_STATUS);
    endfunction : wr_hit_rd

    // ----------------------------------------------------------------
    // Write channel handshake
    // ----------------------------------------------------------------
    // Address and data are caught in either order and held until the
    // response is taken, so only one write is ever in flight.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (s_axi_awvalid && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end else if (bvalid_ff && s_axi_bready) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
        end
    end

    // Data half of the write
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (s_axi_wvalid && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end else if (bvalid_ff && s_axi_bready) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
        end
    end

    // Write response, unmapped or read-only targets answer SLVERR
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= AFE_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? AFE_RESP_OKAY : AFE_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register storage
    // ----------------------------------------------------------------
    // Converter control word: reference enable lives in bit 0
    always_ff @(posedge clk) begin
        if (!resetn) begin
            adc_ctrl_ff <= RST_ADC_CTRL;
        end else if (wr_fire && wr_idx == IDX_ADC_CTRL) begin
            adc_ctrl_ff <= merge_lanes(adc_ctrl_ff, w_data_ff, w_strb_ff, MASK_ADC_CTRL);
        end
    end

    // I/O control word; the mask keeps bit 14 and bits 31:24 at zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            io_ctrl_ff <= RST_IO_CTRL;
        end else if (wr_fire && wr_idx == IDX_IO_CTRL) begin
            io_ctrl_ff <= merge_lanes(io_ctrl_ff, w_data_ff, w_strb_ff,
                                      MASK_IO_CTRL);
        end
    end

    // Active setup configuration: polarity, reference select, gain
    always_ff @(posedge clk) begin
        if (!resetn) begin
            setup_cfg_ff <= RST_SETUP_CFG;
        end else if (wr_fire && wr_idx == IDX_SETUP_CFG) begin
            setup_cfg_ff <= merge_lanes(setup_cfg_ff, w_data_ff, w_strb_ff, MASK_SETUP_CFG);
        end
    end

    // ----------------------------------------------------------------
    // Filter restart request
    // ----------------------------------------------------------------
    // Any write to the control or setup word restarts the modulator and
    // filter, which is how software settles after a mux change.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            filter_reset_ff <= 1'b0;
        end else begin
            filter_reset_ff <= wr_fire && (wr_idx == IDX_ADC_CTRL ||
                                           wr_idx == IDX_SETUP_CFG);
        end
    end

    // ----------------------------------------------------------------
    // Front-end drive decode
    // ----------------------------------------------------------------
    always_comb begin
        nxt_drive             = '0;
        nxt_drive.gain_select = setup_cfg_ff[CFG_GAIN_LSB +: 3];
        // Stage A covers x2..x8; stage B is added above x8
        nxt_drive.stage_a_en  = nxt_drive.gain_select > GAIN_BYPASS_MAX;
        nxt_drive.stage_b_en  = nxt_drive.gain_select > GAIN_ONE_MAX;
        nxt_drive.int_ref_power = adc_ctrl_ff[CTRL_REF_ON_BIT];
        nxt_drive.ref_route   = afe_ref_e'(setup_cfg_ff[CFG_REFSEL_LSB +: 2]);
        nxt_drive.bipolar     = setup_cfg_ff[CFG_POLAR_BIT];
        // Currents ignore the reference enable entirely
        nxt_drive.current_a_magnitude  = io_ctrl_ff[IO_MAG_A_LSB +: 3];
        nxt_drive.current_b_magnitude  = io_ctrl_ff[IO_MAG_B_LSB +: 3];
        // No arbitration: both sources may name the same pin
        nxt_drive.current_a_pin_select = io_ctrl_ff[IO_PIN_A_LSB +: 4];
        nxt_drive.current_b_pin_select = io_ctrl_ff[IO_PIN_B_LSB +: 4];
        nxt_drive.bridge_switch_close  = io_ctrl_ff[IO_SW_BIT];
    end

    // Drive outputs are registered one cycle behind the register bank
    always_ff @(posedge clk) begin
        if (!resetn) begin
            drive_ff <= '0;
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    // ----------------------------------------------------------------
    // General-purpose outputs
    // ----------------------------------------------------------------
    // Value is forced low while disabled so a tristated pin never shows
    // a stale level if the pad ignores the enable.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            gpo_ff    <= '0;
            gpo_oe_ff <= '0;
        end else begin
            gpo_oe_ff <= io_ctrl_ff[IO_OE_LSB +: 4];
            gpo_ff    <= io_ctrl_ff[IO_VAL_LSB +: 4] & io_ctrl_ff[IO_OE_LSB +: 4];
        end
    end

    // ----------------------------------------------------------------
    // Result formatting
    // ----------------------------------------------------------------
    afe_code_format #(
        .W             (AFE_CODE_W)
    ) u_format (
        .clk           (clk),
        .resetn        (resetn),
        .bipolar       (setup_cfg_ff[CFG_POLAR_BIT]),
        .sample_valid  (sample_valid),
        .sample        (sample_value),
        .code_valid_ff (code_valid),
        .code_ff       (result_hold)
    );

    // New-result flag: a fresh code beats a clearing read in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_new_ff <= 1'b0;
        end else if (code_valid) begin
            result_new_ff <= 1'b1;
        end else if (rd_fire && rd_idx == IDX_RESULT) begin
            result_new_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    // Data is captured at the address handshake and answered next cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
            rresp_ff   <= AFE_RESP_OKAY;
            rdata_ff   <= '0;
        end else if (rd_fire) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b1;
            rresp_ff   <= rd_hit ? AFE_RESP_OKAY : AFE_RESP_SLVERR;
            case (rd_idx)
                IDX_ADC_CTRL:  rdata_ff <= adc_ctrl_ff;
                IDX_IO_CTRL:   rdata_ff <= io_ctrl_ff;
                IDX_SETUP_CFG: rdata_ff <= setup_cfg_ff;
                IDX_RESULT:    rdata_ff <= {{(32-AFE_CODE_W){1'b0}}, result_hold};
                IDX_STATUS:    rdata_ff <= {29'h0, drive_ff.stage_b_en,
                                            drive_ff.stage_a_en, result_new_ff};
                default:       rdata_ff <= '0;
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            arready_ff <= 1'b1;
            rvalid_ff  <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Output assignments
    // ----------------------------------------------------------------
    assign s_axi_awready          = awready_ff;
    assign s_axi_wready           = wready_ff;
    assign s_axi_bvalid           = bvalid_ff;
    assign s_axi_bresp            = bresp_ff;
    assign s_axi_arready          = arready_ff;
    assign s_axi_rvalid           = rvalid_ff;
    assign s_axi_rresp            = rresp_ff;
    assign s_axi_rdata            = rdata_ff;
    assign result_valid           = code_valid;
    assign result_code            = result_hold;
    assign afe_drive              = drive_ff;
    assign general_output_pins    = gpo_ff;
    assign general_output_pins_oe = gpo_oe_ff;
    assign filter_reset           = filter_reset_ff;

endmodule : afe_control

`default_nettype wire

//--- afe_control_sva.sv
// Purpose: Port checks for afe_control
// Assumes: one clock, sync low reset
// Notes: bound after the module
`default_nettype none
module afe_control_sva
    import afe_pkg::*;
(
    input wire logic                  clk,           // Clock
    input wire logic                  resetn,        // Reset
    input wire logic                  s_axi_arvalid, // AR valid
    input wire logic                  s_axi_arready, // AR ready
    input wire logic                  s_axi_rvalid,  // R valid
    input wire logic                  sample_valid,  // Strobe in
    input wire logic [AFE_CODE_W:0]   sample_value,  // Sample
    input wire logic                  result_valid,  // Strobe out
    input wire logic [AFE_CODE_W-1:0] result_code,   // Code
    input wire afe_drive_s            afe_drive,     // Drive
    input wire logic [3:0]            general_output_pins,   // Levels
    input wire logic [3:0]            general_output_pins_oe // Enables
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Undriven pins must never show a level
    pins_oe_a: assert property ((general_output_pins & ~general_output_pins_oe) == 4'h0)
        else $error("level on undriven pin");
    stage_a_a: assert property (afe_drive.stage_a_en == (afe_drive.gain_select != 3'h0))
        else $error("stage one decode");
    stage_b_a: assert property (afe_drive.stage_b_en == afe_drive.gain_select[2])
        else $error("stage two decode");
    code_strobe_a: assert property (sample_valid |=> result_valid)
        else $error("no code strobe");
    strobe_cause_a: assert property (result_valid |-> $past(sample_valid))
        else $error("stray code strobe");
    uni_floor_a: assert property (sample_valid && !afe_drive.bipolar && $signed(sample_value) <= 0
        |=> result_code == 24'h0) else $error("unipolar floor");
    bip_mid_a: assert property (sample_valid && afe_drive.bipolar && sample_value == '0
        |=> result_code == 24'h800000) else $error("bipolar midscale");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule : afe_control_sva
bind afe_control afe_control_sva u_sva (.*);
`default_nettype wire

//--- afe_sensor_model.sv
// Purpose: External sensor mux on the general outputs
// Assumes: chan is level AND enable
// Notes: levels reach both clamp limits
`default_nettype none
module afe_sensor_model
    import afe_pkg::*;
(
    input  wire logic             clk,          // Clock
    input  wire logic             fire,         // Take sample
    input  wire logic [3:0]       chan,         // Mux select
    output logic                  sample_valid, // Strobe
    output logic [AFE_CODE_W:0]   sample_value  // Level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Selected sensor level, below zero up to full scale exactly
    always_comb begin
        case (chan[1:0])
            2'h0: sample_value = 25'h0;
            2'h1: sample_value = 25'h0800000;
            2'h2: sample_value = 25'h0ffffff;
            default: sample_value = 25'h1000000;
        endcase
    end
    always_ff @(posedge clk) sample_valid <= fire;
endmodule : afe_sensor_model
`default_nettype wire

//--- tb.sv
// Purpose: Self-checking bench for afe_control
// Assumes: AXI4-Lite master tasks, 25 ns clock
// Notes: sensor model sits on the general outputs
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import afe_pkg::*;
    logic clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, fire = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sample_valid, result_valid, filter_reset;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf, general_output_pins, general_output_pins_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [24:0] sample_value;
    logic [23:0] result_code;
    afe_drive_s afe_drive;
    int fails = 0, n_checks = 0, cyc = 0;
    logic [23:0] exp_code [8] = '{24'h0, 24'h800000, 24'hffffff, 24'h0, 24'h800000, 24'hc00000, 24'hffffff, 24'h0};
    always #12.5 clk = ~clk;
    afe_control dut (.*);
    afe_sensor_model u_sensor (.clk(clk), .fire(fire), .chan(general_output_pins & general_output_pins_oe),
        .sample_valid(sample_valid), .sample_value(sample_value));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp);
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(rsp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
        @(posedge clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp);
        chk(32'(s_axi_rresp), 32'(rsp));
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // Hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h0c, 32'h0, AFE_RESP_OKAY);
        rd(8'h3c, 32'h0, AFE_RESP_SLVERR);
        wr(8'h08, 32'h1, AFE_RESP_SLVERR);
        wr(8'h0c, 32'hffff_ffff, AFE_RESP_OKAY);
        rd(8'h0c, 32'h00ff_bfff, AFE_RESP_OKAY);
        chk(32'(afe_drive[14:0]), 32'h7fff);
        chk(32'({general_output_pins, general_output_pins_oe}), 32'hff);
        wr(8'h0c, 32'h00f5_2a99, AFE_RESP_OKAY);
        rd(8'h0c, 32'h00f5_2a99, AFE_RESP_OKAY);
        chk(32'({general_output_pins, general_output_pins_oe}), 32'h55);
        wr(8'h04, 32'h1, AFE_RESP_OKAY);
        rd(8'h04, 32'h1, AFE_RESP_OKAY);
        chk(32'({afe_drive.int_ref_power, afe_drive[14:0]}), 32'hab32);
        // Every gain code, reference route cycling alongside
        for (int g = 0; g < 8; g++) begin
            wr(8'h64, 32'(g + (g % 3) * 8), AFE_RESP_OKAY);
            rd(8'h64, 32'(g + (g % 3) * 8), AFE_RESP_OKAY);
            chk(32'({afe_drive.stage_a_en, afe_drive.stage_b_en, afe_drive.gain_select, afe_drive.ref_route}),
                32'({g > 0, g > 3, 3'(g), 2'(g % 3)}));
        end
        // Each mux channel in both ranges; setup rewrite restarts filter
        for (int i = 0; i < 8; i++) begin
            wr(8'h0c, 32'h0003_0000 | 32'((i % 4) << 20), AFE_RESP_OKAY);
            wr(8'h64, 32'((i / 4) << 11), AFE_RESP_OKAY);
            chk(32'(filter_reset), 32'h1);
            rd(8'h64, 32'((i / 4) << 11), AFE_RESP_OKAY);
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            do @(posedge clk); while (!result_valid);
            chk(32'(result_code), 32'(exp_code[i]));
            rd(8'h14, 32'h1, AFE_RESP_OKAY);
            rd(8'h08, 32'(exp_code[i]), AFE_RESP_OKAY);
        end
        rd(8'h14, 32'h0, AFE_RESP_OKAY);
        wrap_up();
    end
endmodule : tb
`default_nettype wire
